// >>> agc_pkg.sv
// package for the speaker gain and battery gain-control block
// assumes a 100 MHz system clock and an apb register port
package agc_pkg;
    // register byte addresses are four times the printed index
    localparam logic [7:0] AGC_IDX_PDM_GAIN  = 8'h0C;
    localparam logic [7:0] AGC_IDX_EMISSION  = 8'h0D;
    localparam logic [7:0] AGC_IDX_BATT_TRIP = 8'h0E;
    localparam logic [7:0] AGC_IDX_HOLD_ATK  = 8'h0F;
    localparam logic [7:0] AGC_IDX_LIM_REL   = 8'h10;
    localparam logic [7:0] AGC_IDX_TIMEOUT   = 8'h11;
    localparam logic [7:0] AGC_IDX_STATUS    = 8'h12;
    // reset values
    localparam logic [7:0] AGC_RST_PDM_GAIN  = 8'h40;
    localparam logic [7:0] AGC_RST_EMISSION  = 8'h1C;
    localparam logic [7:0] AGC_RST_BATT_TRIP = 8'h00;
    localparam logic [7:0] AGC_RST_HOLD_ATK  = 8'h00;
    localparam logic [7:0] AGC_RST_LIM_REL   = 8'h00;
    localparam logic [7:0] AGC_RST_TIMEOUT   = 8'h00;
    // writable bit masks
    localparam logic [7:0] AGC_MSK_PDM_GAIN  = 8'h7F;
    localparam logic [7:0] AGC_MSK_EMISSION  = 8'h1F;
    localparam logic [7:0] AGC_MSK_BATT_TRIP = 8'h1F;
    localparam logic [7:0] AGC_MSK_HOLD_ATK  = 8'hFF;
    localparam logic [7:0] AGC_MSK_LIM_REL   = 8'h7F;
    localparam logic [7:0] AGC_MSK_TIMEOUT   = 8'h03;
    // field positions
    localparam int AGC_POS_DAC_MAP   = 5;
    localparam int AGC_POS_SPK_GAIN  = 0;
    localparam int AGC_POS_EDGE_RATE = 3;
    localparam int AGC_POS_SPREAD    = 0;
    localparam int AGC_POS_TRIP      = 0;
    localparam int AGC_POS_HOLD      = 4;
    localparam int AGC_POS_ATTACK    = 0;
    localparam int AGC_POS_LIMIT     = 4;
    localparam int AGC_POS_RELEASE   = 0;
    localparam int AGC_POS_TMO       = 0;
    // timing, in printed units, and the clock
    localparam int AGC_CLK_HZ        = 100_000_000;
    localparam int GAIN_HOLD_TIME_BASE_MS  = 10;
    localparam int GAIN_HOLD_TIME_STEP_MS  = 35;
    localparam int AGC_ATK_BASE_US   = 10;
    localparam int AGC_ATK_STEP_US   = 35;
    localparam int AGC_REL_BASE_MS   = 5;
    localparam int AGC_REL_STEP_MS   = 70;
    localparam int AGC_TMO_1_MS      = 565;
    localparam int AGC_TMO_2_MS      = 775;
    localparam int AGC_TMO_3_MS      = 985;
    localparam int AGC_CYC_PER_US    = AGC_CLK_HZ / 1_000_000;
    localparam int AGC_CYC_PER_MS    = AGC_CLK_HZ / 1_000;
    localparam logic [3:0] GAIN_HOLD_TIME_INFINITE = 4'hF;
    localparam logic [1:0] AGC_TMO_OFF       = 2'b00;
    localparam logic [3:0] GAIN_ATTENUATION_LIMIT_DB    = 4'd9;
    localparam logic [7:0] AGC_DBV_STEP      = 8'h01;

    typedef enum logic [2:0] {
        AGC_IDLE    = 3'b000,
        GAIN_ATTACK_RATE  = 3'b001,
        GAIN_HOLD_TIME    = 3'b010,
        GAIN_RELEASE_RATE = 3'b011,
        AGC_STANDBY = 3'b100
    } agc_state_t;

    // settings driven to the output stage
    typedef struct packed {
        logic [1:0] pdm_output_level_map;
        logic [4:0] pdm_speaker_gain;
        logic [1:0] output_edge_rate;
        logic [2:0] spread_spectrum_depth;
    } agc_stage_cfg_t;

    // gain-control state seen outside
    typedef struct packed {
        logic       standby;
        logic       attenuation_limit_reached;
        logic [3:0] attenuation_db;
        agc_state_t state;
    } agc_status_t;
endpackage

// >>> agc_top.sv
// class-d speaker gain settings and battery-voltage gain control
// assumes an apb master on sys_clk_i and a comparator that reports
// supply at or below the trip level; the threshold code and table
// select are handed to that comparator
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module agc_top
    import agc_pkg::*;
#(
    parameter int unsigned HOLD_STEP_CYC = GAIN_HOLD_TIME_STEP_MS * AGC_CYC_PER_MS,
    parameter int unsigned HOLD_BASE_CYC = GAIN_HOLD_TIME_BASE_MS * AGC_CYC_PER_MS,
    parameter int unsigned REL_STEP_CYC  = AGC_REL_STEP_MS * AGC_CYC_PER_MS,
    parameter int unsigned REL_BASE_CYC  = AGC_REL_BASE_MS * AGC_CYC_PER_MS,
    parameter int unsigned ATK_STEP_CYC  = AGC_ATK_STEP_US * AGC_CYC_PER_US,
    parameter int unsigned ATK_BASE_CYC  = AGC_ATK_BASE_US * AGC_CYC_PER_US,
    parameter int unsigned TMO_1_CYC     = AGC_TMO_1_MS * AGC_CYC_PER_MS,
    parameter int unsigned TMO_2_CYC     = AGC_TMO_2_MS * AGC_CYC_PER_MS,
    parameter int unsigned TMO_3_CYC     = AGC_TMO_3_MS * AGC_CYC_PER_MS
)(
    // clock and reset
    input  wire logic            sys_clk_i,
    input  wire logic            rst_n_i,
    // apb slave
    input  wire logic            psel_i,
    input  wire logic            penable_i,
    input  wire logic            pwrite_i,
    input  wire logic [7:0]      paddr_i,
    input  wire logic [31:0]     pwdata_i,
    input  wire logic [3:0]      pstrb_i,
    output logic      [31:0]     prdata_o,
    output logic                 pready_o,
    output logic                 pslverr_o,
    // pins
    input  wire logic            cell_count_select_i,
    input  wire logic            supply_below_trip_i,
    // comparator setup
    output logic      [4:0]      battery_trip_level_o,
    output logic                 three_cell_table_o,
    // output stage and status
    output agc_pkg::agc_stage_cfg_t stage_cfg_o,
    output agc_pkg::agc_status_t    status_o
);
    import agc_pkg::*;

    logic [7:0]  pdm_q;
    logic [7:0]  emi_q;
    logic [7:0]  trip_q;
    logic [7:0]  hold_q;
    logic [7:0]  lim_q;
    logic [7:0]  tmo_q;
    logic        cell_s1_q;
    logic        cell_s2_q;
    logic        trip_s1_q;
    logic        trip_s2_q;
    agc_state_t  state_q, state_d;
    logic [3:0]  att_q, att_d;
    logic [31:0] tmr_q, tmr_d;
    logic [31:0] tmo_cnt_q, tmo_cnt_d;
    logic        standby_q, standby_d;
    logic [31:0] prdata_q;

    // bus decode
    // only the low byte lane carries register data
    wire         acc      = psel_i & penable_i;
    wire         wr_en    = acc & pwrite_i & pstrb_i[0];
    wire  [7:0]  idx      = {2'b00, paddr_i[7:2]};
    wire         aligned  = (paddr_i[1:0] == 2'b00);
    wire         hit_pdm  = aligned & (idx == AGC_IDX_PDM_GAIN);
    wire         hit_emi  = aligned & (idx == AGC_IDX_EMISSION);
    wire         hit_trip = aligned & (idx == AGC_IDX_BATT_TRIP);
    wire         hit_hold = aligned & (idx == AGC_IDX_HOLD_ATK);
    wire         hit_lim  = aligned & (idx == AGC_IDX_LIM_REL);
    wire         hit_tmo  = aligned & (idx == AGC_IDX_TIMEOUT);
    wire         hit_sts  = aligned & (idx == AGC_IDX_STATUS);
    wire         mapped   = hit_pdm | hit_emi | hit_trip | hit_hold | hit_lim | hit_tmo | hit_sts;
    wire  [7:0]  wbyte    = pwdata_i[7:0];
    wire  [7:0]  sts_byte = {standby_q, status_o.attenuation_limit_reached, 3'b000, state_q};
    wire  [7:0]  rd_byte  = hit_pdm  ? pdm_q  :
                            hit_emi  ? emi_q  :
                            hit_trip ? trip_q :
                            hit_hold ? hold_q :
                            hit_lim  ? lim_q  :
                            hit_tmo  ? tmo_q  :
                            hit_sts  ? sts_byte : 8'h00;

    // masked write keeps reserved bits at zero
    function automatic logic [7:0] upd(input logic [7:0] old, input logic hit, input logic [7:0] msk);
        upd = (wr_en & hit) ? (wbyte & msk) : old;
    endfunction

    // one step of a linear time table: base plus code times step
    function automatic logic [31:0] lin(input int unsigned base, input int unsigned step, input logic [3:0] code);
        lin = 32'(base + step * 32'(code));
    endfunction

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pdm_q  <= AGC_RST_PDM_GAIN;
            emi_q  <= AGC_RST_EMISSION;
            trip_q <= AGC_RST_BATT_TRIP;
            hold_q <= AGC_RST_HOLD_ATK;
            lim_q  <= AGC_RST_LIM_REL;
            tmo_q  <= AGC_RST_TIMEOUT;
        end
        else
        begin
            pdm_q  <= upd(pdm_q,  hit_pdm,  AGC_MSK_PDM_GAIN);
            emi_q  <= upd(emi_q,  hit_emi,  AGC_MSK_EMISSION);
            trip_q <= upd(trip_q, hit_trip, AGC_MSK_BATT_TRIP);
            hold_q <= upd(hold_q, hit_hold, AGC_MSK_HOLD_ATK);
            lim_q  <= upd(lim_q,  hit_lim,  AGC_MSK_LIM_REL);
            tmo_q  <= upd(tmo_q,  hit_tmo,  AGC_MSK_TIMEOUT);
        end
    end

    // zero-wait apb; unmapped or misaligned addresses raise pslverr
    // read data is caught in the setup cycle so it already stands in the access phase
    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prdata_q <= 32'h0000_0000;
        else if (psel_i & ~penable_i & ~pwrite_i)
            prdata_q <= {24'h00_0000, rd_byte};
    end
    assign prdata_o = prdata_q;

    // pin synchronisers
    // both pins are asynchronous to sys_clk_i; nothing but the second stage reads the first
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cell_s1_q <= 1'b0;
            cell_s2_q <= 1'b0;
            trip_s1_q <= 1'b0;
            trip_s2_q <= 1'b0;
        end
        else
        begin
            cell_s1_q <= cell_count_select_i;
            cell_s2_q <= cell_s1_q;
            trip_s1_q <= supply_below_trip_i;
            trip_s2_q <= trip_s1_q;
        end
    end

    // field views
    wire  [3:0]  hold_code = hold_q[AGC_POS_HOLD +: 4];
    wire  [3:0]  atk_code  = hold_q[AGC_POS_ATTACK +: 4];
    wire  [2:0]  lim_code  = lim_q[AGC_POS_LIMIT +: 3];
    wire  [3:0]  rel_code  = lim_q[AGC_POS_RELEASE +: 4];
    wire  [1:0]  tmo_code  = tmo_q[AGC_POS_TMO +: 2];
    wire  [3:0]  att_max   = GAIN_ATTENUATION_LIMIT_DB - {1'b0, lim_code};
    wire  [31:0] hold_cyc  = lin(HOLD_BASE_CYC, HOLD_STEP_CYC, hold_code);
    wire  [31:0] atk_cyc   = lin(ATK_BASE_CYC, ATK_STEP_CYC, atk_code);
    wire  [31:0] rel_cyc   = lin(REL_BASE_CYC, REL_STEP_CYC, rel_code);
    wire  [31:0] tmo_cyc   = (tmo_code == 2'b01) ? 32'(TMO_1_CYC) :
                             (tmo_code == 2'b10) ? 32'(TMO_2_CYC) : 32'(TMO_3_CYC);
    wire         at_limit  = (att_q >= att_max);
    wire         tmr_done  = (tmr_q == 32'h0000_0000);

    // gain-control sequence: trip, attack to limit, hold, release
    always_comb
    begin
        state_d = state_q;
        att_d   = att_q;
        tmr_d   = tmr_q;
        unique case (state_q)
            AGC_IDLE:
                if (trip_s2_q)
                begin
                    state_d = GAIN_ATTACK_RATE;
                    tmr_d   = 32'h0000_0000;
                end
            GAIN_ATTACK_RATE:
                if (at_limit | ~trip_s2_q)
                begin
                    state_d = GAIN_HOLD_TIME;
                    tmr_d   = hold_cyc - 32'h1;
                end
                else if (tmr_done)
                begin
                    att_d = att_q + 4'h1;
                    tmr_d = atk_cyc - 32'h1;
                end
                else
                    tmr_d = tmr_q - 32'h1;
            GAIN_HOLD_TIME:
                if (trip_s2_q & ~at_limit)
                begin
                    // a stale hold count must not delay the next attack step
                    state_d = GAIN_ATTACK_RATE;
                    tmr_d   = 32'h0000_0000;
                end
                else if (trip_s2_q)
                    tmr_d = hold_cyc - 32'h1;
                else if (hold_code == GAIN_HOLD_TIME_INFINITE)
                    tmr_d = tmr_q;
                else if (tmr_done)
                begin
                    state_d = GAIN_RELEASE_RATE;
                    tmr_d   = rel_cyc - 32'h1;
                end
                else
                    tmr_d = tmr_q - 32'h1;
            GAIN_RELEASE_RATE:
                if (trip_s2_q)
                begin
                    state_d = GAIN_ATTACK_RATE;
                    tmr_d   = 32'h0000_0000;
                end
                else if (att_q == 4'h0)
                    state_d = AGC_IDLE;
                else if (tmr_done)
                begin
                    // the reload edge counts, so one step spans exactly rel_cyc clocks
                    att_d = att_q - 4'h1;
                    tmr_d = rel_cyc - 32'h1;
                end
                else
                    tmr_d = tmr_q - 32'h1;
            AGC_STANDBY:
                state_d = AGC_STANDBY;
            default:
                state_d = AGC_IDLE;
        endcase
        // leaving timeout standby only by disabling the timeout
        if (state_q == AGC_STANDBY && tmo_code == AGC_TMO_OFF)
        begin
            state_d = AGC_IDLE;
            att_d   = 4'h0;
            tmr_d   = 32'h0000_0000;
        end
    end

    // standby timeout runs only while sitting at the limit
    // the count restarts whenever the limit is left, so short visits do not add up
    always_comb
    begin
        tmo_cnt_d = 32'h0000_0000;
        standby_d = standby_q & (tmo_code != AGC_TMO_OFF);
        if (state_q != AGC_IDLE && at_limit && tmo_code != AGC_TMO_OFF && !standby_q)
        begin
            tmo_cnt_d = tmo_cnt_q + 32'h1;
            if (tmo_cnt_q + 32'h1 >= tmo_cyc)
                standby_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q   <= AGC_IDLE;
            att_q     <= 4'h0;
            tmr_q     <= 32'h0000_0000;
            tmo_cnt_q <= 32'h0000_0000;
            standby_q <= 1'b0;
        end
        else
        begin
            state_q   <= (standby_d & ~standby_q) ? AGC_STANDBY : state_d;
            att_q     <= att_d;
            tmr_q     <= tmr_d;
            tmo_cnt_q <= tmo_cnt_d;
            standby_q <= standby_d;
        end
    end

    // outputs from registers, the limit flag through a compare; fields act the cycle after the write
    assign stage_cfg_o.pdm_output_level_map  = pdm_q[AGC_POS_DAC_MAP +: 2];
    assign stage_cfg_o.pdm_speaker_gain      = pdm_q[AGC_POS_SPK_GAIN +: 5];
    assign stage_cfg_o.output_edge_rate      = emi_q[AGC_POS_EDGE_RATE +: 2];
    assign stage_cfg_o.spread_spectrum_depth = emi_q[AGC_POS_SPREAD +: 3];
    assign battery_trip_level_o              = trip_q[AGC_POS_TRIP +: 5];
    assign three_cell_table_o                = cell_s2_q;
    assign status_o.standby                  = standby_q;
    assign status_o.attenuation_limit_reached = at_limit & (state_q != AGC_IDLE);
    assign status_o.attenuation_db           = att_q;
    assign status_o.state                    = state_q;
endmodule

// >>> agc_top_assertions.sv
// checker for the gain-control block, bound to agc_top
// assumes one clock domain and apb byte addresses of index times four
`timescale 1ns/1ps
module agc_checker
    import agc_pkg::*;
(
    // clock, reset and apb
    input wire logic                   sys_clk_i,
    input wire logic                   rst_n_i,
    input wire logic                   psel_i,
    input wire logic                   penable_i,
    input wire logic                   pwrite_i,
    input wire logic [7:0]             paddr_i,
    input wire logic [31:0]            pwdata_i,
    input wire logic [3:0]             pstrb_i,
    input wire logic [31:0]            prdata_o,
    input wire logic                   pslverr_o,
    // pins and outputs
    input wire logic                   cell_count_select_i,
    input wire logic                   supply_below_trip_i,
    input wire logic [4:0]             battery_trip_level_o,
    input wire logic                   three_cell_table_o,
    input wire agc_pkg::agc_stage_cfg_t stage_cfg_o,
    input wire agc_pkg::agc_status_t    status_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       wr_ok;
    logic       bad_addr;
    logic [2:0] lim_q;
    logic [1:0] tmo_q;
    assign wr_ok = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign bad_addr = paddr_i[1:0] != 2'b00 || paddr_i < 8'h30 || paddr_i > 8'h48;
    // shadows of two fields, since the checker sees only the ports
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lim_q <= 3'h0;
            tmo_q <= 2'h0;
        end
        else if (wr_ok)
        begin
            if (paddr_i == 8'h40) lim_q <= pwdata_i[6:4];
            if (paddr_i == 8'h44) tmo_q <= pwdata_i[1:0];
        end
    end
    addr_err_a: assert property (psel_i && penable_i |-> pslverr_o == bad_addr)
        else $error("address error flag wrong");
    refused_read_a: assert property (psel_i && penable_i && !pwrite_i && bad_addr |-> prdata_o == 32'h0)
        else $error("refused read not zero");
    pdm_write_a: assert property (wr_ok && paddr_i == 8'h30 |=>
        stage_cfg_o.pdm_output_level_map == $past(pwdata_i[6:5]) && stage_cfg_o.pdm_speaker_gain == $past(pwdata_i[4:0]))
        else $error("pdm settings not applied");
    emission_write_a: assert property (wr_ok && paddr_i == 8'h34 |=>
        stage_cfg_o.output_edge_rate == $past(pwdata_i[4:3]) && stage_cfg_o.spread_spectrum_depth == $past(pwdata_i[2:0]))
        else $error("emission settings not applied");
    trip_write_a: assert property (wr_ok && paddr_i == 8'h38 |=> battery_trip_level_o == $past(pwdata_i[4:0]))
        else $error("trip level not applied");
    cell_table_a: assert property ($changed(cell_count_select_i) |->
        ##2 three_cell_table_o == $past(cell_count_select_i, 2))
        else $error("table select lags wrongly");
    att_limit_a: assert property (status_o.attenuation_db <= 4'd9 - {1'b0, lim_q})
        else $error("attenuation beyond limit");
    attack_start_a: assert property ($rose(supply_below_trip_i) && status_o.state == AGC_IDLE |->
        ##[2:5] status_o.state == GAIN_ATTACK_RATE && status_o.attenuation_db != 4'h0)
        else $error("attack did not start");
    standby_off_a: assert property (tmo_q == 2'b00 && !status_o.standby |=> !status_o.standby)
        else $error("standby with timeout off");
    standby_exit_a: assert property (wr_ok && paddr_i == 8'h44 && pwdata_i[1:0] == 2'b00 |->
        ##[1:2] !status_o.standby)
        else $error("standby not left");
    standby_state_a: assert property (status_o.standby == (status_o.state == AGC_STANDBY))
        else $error("standby flag and state differ");
endmodule
bind agc_top agc_checker agc_checker_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .cell_count_select_i(cell_count_select_i), .supply_below_trip_i(supply_below_trip_i),
    .battery_trip_level_o(battery_trip_level_o), .three_cell_table_o(three_cell_table_o),
    .stage_cfg_o(stage_cfg_o), .status_o(status_o));

// >>> testbench.sv
// self-checking bench for the gain-control block
// assumes agc_top with shortened timing parameters; times are counted in clocks
`timescale 1ns/1ps
module testbench;
    import agc_pkg::*;
    localparam int ATK = 4;
    localparam int HLD = 10;
    localparam int HST = 20;
    localparam int REL = 10;
    localparam int TMO = 50;
    localparam int TST = 20;
    logic                   sys_clk_i = 1'b0;
    logic                   rst_n_i = 1'b0;
    logic                   psel_i = 1'b0;
    logic                   penable_i = 1'b0;
    logic                   pwrite_i = 1'b0;
    logic [7:0]             paddr_i = 8'h00;
    logic [31:0]            pwdata_i = 32'h0;
    logic [3:0]             pstrb_i = 4'hF;
    logic [31:0]            prdata_o;
    logic                   pready_o;
    logic                   pslverr_o;
    logic                   cell_count_select_i = 1'b0;
    logic                   supply_below_trip_i = 1'b0;
    logic [4:0]             battery_trip_level_o;
    logic                   three_cell_table_o;
    agc_stage_cfg_t         stage_cfg_o;
    agc_status_t            status_o;
    int                     num_errors = 0;
    int                     num_checks = 0;
    int                     n;
    logic [31:0]            rd;
    logic                   err;
    logic [7:0]             a;
    logic [7:0]             rst_v [6] = '{8'h40, 8'h1C, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]             msk_v [6] = '{8'h7F, 8'h1F, 8'h1F, 8'hFF, 8'h7F, 8'h03};
    logic [4:0]             gain_v [5] = '{5'h00, 5'h08, 5'h0E, 5'h14, 5'h1A};
    always #5 sys_clk_i = ~sys_clk_i;
    agc_top #(.HOLD_STEP_CYC(HST), .HOLD_BASE_CYC(HLD), .REL_STEP_CYC(HST), .REL_BASE_CYC(REL), .ATK_STEP_CYC(ATK),
        .ATK_BASE_CYC(ATK), .TMO_1_CYC(TMO), .TMO_2_CYC(TMO + TST), .TMO_3_CYC(TMO + 2 * TST)) agc_top_inst (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cell_count_select_i(cell_count_select_i), .supply_below_trip_i(supply_below_trip_i),
        .battery_trip_level_o(battery_trip_level_o), .three_cell_table_o(three_cell_table_o),
        .stage_cfg_o(stage_cfg_o), .status_o(status_o));
    task automatic close_out();
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hang();
        $display("BAD %0t wait expired", $time);
        num_errors++;
        close_out();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    // one apb transfer; an idle edge follows so psel never gets two values in one step
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= {24'h0, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk_i);
            if (pready_o === 1'b1)
                break;
        end
        if (n == 20)
            hang();
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // sel 0: state s, 1: limit reached, 2: standby; n returns the clocks waited
    task automatic wait_for(input int sel, input agc_state_t s);
        logic hit;
        for (n = 1; n < 3000; n++)
        begin
            @(posedge sys_clk_i);
            hit = sel == 0 ? status_o.state === s : sel == 1 ? status_o.attenuation_limit_reached === 1'b1
                : status_o.standby === 1'b1;
            if (hit)
                return;
        end
        hang();
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(stage_cfg_o, {2'b10, 5'h00, 2'b11, 3'b100});
        for (int i = 0; i < 6; i++)
        begin
            a = 8'h30 + 8'(4 * i);
            apb(1'b0, a, 8'h00);
            chk(rd, {24'h0, rst_v[i]});
            apb(1'b1, a, 8'hFF);
            apb(1'b0, a, 8'h00);
            chk(rd, {24'h0, msk_v[i]});
            apb(1'b1, a, 8'h00);
        end
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, 8'h34, {3'b000, i[1:0], i[2:0]});
            chk(stage_cfg_o.output_edge_rate, i[1:0]);
            chk(stage_cfg_o.spread_spectrum_depth, i[2:0]);
        end
        for (int i = 0; i < 5; i++)
        begin
            cell_count_select_i <= i[0];
            apb(1'b1, 8'h30, {1'b0, i[1:0], gain_v[i]});
            apb(1'b1, 8'h38, {3'b000, gain_v[i]});
            chk(stage_cfg_o.pdm_output_level_map, i[1:0]);
            chk(stage_cfg_o.pdm_speaker_gain, gain_v[i]);
            chk(battery_trip_level_o, gain_v[i]);
            chk(three_cell_table_o, i[0]);
        end
        apb(1'b1, 8'h4C, 8'h55);
        chk(err, 1'b1);
        apb(1'b0, 8'h31, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h48, 8'hFF);
        chk(err, 1'b0);
        pstrb_i <= 4'h0;
        apb(1'b1, 8'h38, 8'h05);
        pstrb_i <= 4'hF;
        apb(1'b0, 8'h38, 8'h00);
        chk(rd, 32'h1A);
        // limit 6 dB, hold code 1, attack code 1, release code 0, no timeout
        apb(1'b1, 8'h40, 8'h30);
        apb(1'b1, 8'h3C, 8'h11);
        supply_below_trip_i <= 1'b1;
        wait_for(1, AGC_IDLE);
        chk(n >= 39 && n <= 47, 1'b1);
        chk(status_o.attenuation_db, 4'd6);
        supply_below_trip_i <= 1'b0;
        wait_for(0, GAIN_RELEASE_RATE);
        chk(n >= HLD + HST - 1 && n <= HLD + HST + 6, 1'b1);
        wait_for(0, AGC_IDLE);
        chk(n >= 6 * REL - 4 && n <= 6 * REL + 4, 1'b1);
        chk(status_o.attenuation_db, 4'd0);
        // infinite hold: only the timeout ends the episode
        apb(1'b1, 8'h40, 8'h70);
        apb(1'b1, 8'h3C, 8'hF0);
        for (int c = 1; c < 4; c++)
        begin
            apb(1'b1, 8'h44, 8'(c));
            supply_below_trip_i <= 1'b1;
            wait_for(1, AGC_IDLE);
            wait_for(2, AGC_IDLE);
            chk(n >= TMO + TST * (c - 1) - 4 && n <= TMO + TST * (c - 1) + 4, 1'b1);
            supply_below_trip_i <= 1'b0;
            apb(1'b1, 8'h44, 8'h00);
            @(posedge sys_clk_i);
            chk(status_o, 32'h0);
        end
        supply_below_trip_i <= 1'b1;
        wait_for(1, AGC_IDLE);
        supply_below_trip_i <= 1'b0;
        repeat (300) @(posedge sys_clk_i);
        chk(status_o.state, GAIN_HOLD_TIME);
        chk(status_o.standby, 1'b0);
        apb(1'b0, 8'h48, 8'h00);
        chk(rd, 32'h42);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk(status_o, 32'h0);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        apb(1'b0, 8'h3C, 8'h00);
        chk(rd, 32'h0);
        close_out();
    end
endmodule
